// *** rtl/lcd_device_end.sv ***
// display controller end: strap select, nibble assembly, init and instructions
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "lcd_port_consts.svh"
// Overview of operation
// - narrow mode moves each byte in two transfers
// - narrow mode uses only upper four lines
// - upper nibble first, lower nibble second
// - busy rises only after second nibble
// - wide mode moves byte in one transfer
// - straps select parallel, I2C or SPI; only the parallel port is built, other codes leave the bus unused
// - byte-wide host drives strobe, select, direction, data
// - power-up self-initialisation without host
// - busy held high through whole initialisation
// - init fills display memory with 20H
// - init: wide bus, one line, small font
// - init: increment address, no display shift
// - host initialises when internal reset fails
// - status read: busy bit7, address bits6-0
// - host waits for busy low first
// - width selector: 1 wide, 0 narrow
module lcd_device_end
	import lcd_port_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	lcd_bus_if.device       bus,
	input  wire logic       interfaceStrapHigh,
	input  wire logic       interfaceStrapLow,
	output logic            busyIndication,
	output logic [1:0]      ifMode,
	output logic            wideBus,
	output logic            twoLine,
	output logic            bigFont,
	output logic            displayOn,
	output logic            cursorOn,
	output logic            blinkOn,
	output logic            addrIncrement,
	output logic            displayShift,
	output logic [6:0]      addressCounter
);
	logic [7:0] displayDataMemory [0:127];
	coreState_e state, next_state;
	logic       strapDone, next_strapDone;
	logic [1:0] next_ifMode;
	logic       eQ, next_eQ;
	logic       nibSecond, next_nibSecond;
	logic [3:0] nibHold, next_nibHold;
	logic [8:0] fifoMem [0:1];
	logic [8:0] next_fifo0, next_fifo1;
	logic       wrPtr, next_wrPtr, rdPtr, next_rdPtr;
	logic [1:0] count, next_count;
	logic [7:0] execCnt, next_execCnt;
	logic [6:0] fillAddr, next_fillAddr;
	logic       next_busy, next_wide, next_two, next_font, next_disp, next_cur, next_blink;
	logic       next_inc, next_shift;
	logic [6:0] next_addrCnt;
	logic [7:0] next_devData;
	logic       next_devOe;
	logic       memWe;
	logic [6:0] memAddr;
	logic [7:0] memWdata;
	logic       parallel, falling, busyNow, push, pop;
	logic [7:0] rxByte, rdByte, ins;
	logic [8:0] pushWord, popWord;

	// all control state: strap capture, port, buffer, instruction engine
	always_comb begin
		next_state = state;
		next_strapDone = strapDone;
		next_ifMode = ifMode;
		next_nibSecond = nibSecond;
		next_nibHold = nibHold;
		next_fifo0 = fifoMem[0];
		next_fifo1 = fifoMem[1];
		next_wrPtr = wrPtr;
		next_rdPtr = rdPtr;
		next_execCnt = execCnt;
		next_fillAddr = fillAddr;
		next_wide = wideBus;
		next_two = twoLine;
		next_font = bigFont;
		next_disp = displayOn;
		next_cur = cursorOn;
		next_blink = blinkOn;
		next_inc = addrIncrement;
		next_shift = displayShift;
		next_addrCnt = addressCounter;
		memWe = 1'b0;
		memAddr = fillAddr;
		memWdata = `BLANK_CHAR;
		push = 1'b0;
		pop = 1'b0;
		rxByte = 8'h00;
		pushWord = 9'h000;
		popWord = fifoMem[rdPtr];
		ins = popWord[7:0];
		// straps caught once after reset release, never under reset
		if (!strapDone) begin
			next_ifMode = {interfaceStrapHigh, interfaceStrapLow};
			next_strapDone = 1'b1;
		end
		parallel = strapDone && (ifMode == `IF_PARALLEL);
		busyNow = (state != ST_IDLE) || (count != 2'h0);
		next_eQ = bus.enable;
		falling = eQ && !bus.enable;
		// port: latch on the strobe's falling edge, assemble nibbles
		if (parallel && falling) begin
			if (!wideBus && !nibSecond) begin
				next_nibHold = bus.dataLines[7:4];
				next_nibSecond = 1'b1;
			end else begin
				next_nibSecond = 1'b0;
				rxByte = wideBus ? bus.dataLines : {nibHold, bus.dataLines[7:4]};
				pushWord = {bus.registerSelectLine, rxByte};
				// only a complete byte enters the buffer, so busy follows the second half
				if (!bus.readWrite && count != 2'h2) begin
					push = 1'b1;
				end
				// data read done: address moves like a write
				if (bus.readWrite && bus.registerSelectLine) begin
					next_addrCnt = addrIncrement ? addressCounter + 7'h01 : addressCounter - 7'h01;
				end
			end
		end
		if (push) begin
			if (wrPtr) begin
				next_fifo1 = pushWord;
			end else begin
				next_fifo0 = pushWord;
			end
			next_wrPtr = !wrPtr;
		end
		// instruction engine
		case (state)
			ST_INIT_FILL, ST_CLEAR_FILL: begin
				memWe = 1'b1;
				next_fillAddr = fillAddr + 7'h01;
				if (fillAddr == `MEM_LAST) begin
					next_state = ST_IDLE;
					next_addrCnt = 7'h00;
					next_inc = `RST_INC;
					if (state == ST_INIT_FILL) begin
						next_wide = `RST_WIDE;
						next_two = `RST_TWOLINE;
						next_font = `RST_FONT;
						next_disp = `RST_DISP;
						next_cur = `RST_DISP;
						next_blink = `RST_DISP;
						next_shift = `RST_SHIFT;
						next_nibSecond = 1'b0;
					end
				end
			end
			ST_EXEC: begin
				next_execCnt = execCnt - 8'h01;
				if (execCnt == 8'h01) begin
					next_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (count != 2'h0) begin
					pop = 1'b1;
					next_rdPtr = !rdPtr;
					next_state = ST_EXEC;
					next_execCnt = 8'(`EXEC_CYC);
					if (popWord[8]) begin
						memWe = 1'b1;
						memAddr = addressCounter;
						memWdata = ins;
						next_addrCnt = addrIncrement ? addressCounter + 7'h01 : addressCounter - 7'h01;
					end else if (ins[`INS_SETADDR]) begin
						next_addrCnt = ins[6:0];
					end else if (ins[`INS_CGRAM]) begin
						next_state = ST_EXEC; // no glyph memory, only timing
					end else if (ins[`INS_FUNC]) begin
						next_wide = ins[4];
						next_two = ins[3];
						next_font = ins[2];
						if (ins[4] != wideBus) begin
							next_nibSecond = 1'b0;
						end
					end else if (ins[`INS_SHIFT]) begin
						if (!ins[3]) begin
							next_addrCnt = ins[2] ? addressCounter + 7'h01 : addressCounter - 7'h01;
						end
					end else if (ins[`INS_DISP]) begin
						next_disp = ins[2];
						next_cur = ins[1];
						next_blink = ins[0];
					end else if (ins[`INS_ENTRY]) begin
						next_inc = ins[1];
						next_shift = ins[0];
					end else if (ins[`INS_HOME]) begin
						next_addrCnt = 7'h00;
					end else if (ins[`INS_CLEAR]) begin
						next_state = ST_CLEAR_FILL;
						next_fillAddr = 7'h00;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		next_count = count + {1'b0, push} - {1'b0, pop};
		next_busy = (next_state != ST_IDLE) || (next_count != 2'h0);
		// read answer: status or memory, halved in narrow mode
		rdByte = bus.registerSelectLine ? displayDataMemory[addressCounter]
			: {busyNow, addressCounter};
		next_devData = wideBus ? rdByte
			: (nibSecond ? {rdByte[3:0], 4'h0} : {rdByte[7:4], 4'h0});
		next_devOe = parallel && bus.enable && bus.readWrite;
	end

	// display memory, no reset: the fill sequence gives it its content
	always_ff @(posedge ref_clk) begin
		if (memWe) begin
			displayDataMemory[memAddr] <= memWdata;
		end
	end

	// register all control state; reset starts the automatic fill
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_INIT_FILL;
			strapDone <= 1'b0;
			ifMode <= `IF_PARALLEL;
			eQ <= 1'b0;
			nibSecond <= 1'b0;
			nibHold <= 4'h0;
			fifoMem[0] <= 9'h000;
			fifoMem[1] <= 9'h000;
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
			count <= 2'h0;
			execCnt <= 8'h00;
			fillAddr <= 7'h00;
			busyIndication <= 1'b1;
			wideBus <= `RST_WIDE;
			twoLine <= `RST_TWOLINE;
			bigFont <= `RST_FONT;
			displayOn <= `RST_DISP;
			cursorOn <= `RST_DISP;
			blinkOn <= `RST_DISP;
			addrIncrement <= `RST_INC;
			displayShift <= `RST_SHIFT;
			addressCounter <= 7'h00;
			bus.devData <= 8'h00;
			bus.devOe <= 1'b0;
		end else begin
			state <= next_state;
			strapDone <= next_strapDone;
			ifMode <= next_ifMode;
			eQ <= next_eQ;
			nibSecond <= next_nibSecond;
			nibHold <= next_nibHold;
			fifoMem[0] <= next_fifo0;
			fifoMem[1] <= next_fifo1;
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
			execCnt <= next_execCnt;
			fillAddr <= next_fillAddr;
			busyIndication <= next_busy;
			wideBus <= next_wide;
			twoLine <= next_two;
			bigFont <= next_font;
			displayOn <= next_disp;
			cursorOn <= next_cur;
			blinkOn <= next_blink;
			addrIncrement <= next_inc;
			displayShift <= next_shift;
			addressCounter <= next_addrCnt;
			bus.devData <= next_devData;
			bus.devOe <= next_devOe;
		end
	end
endmodule

// *** rtl/lcd_port_consts.svh ***
// constants shared by both ends of the character display parallel port
`ifndef LCD_PORT_CONSTS_SVH
`define LCD_PORT_CONSTS_SVH
// clock, strobe and execution timing in ns, cycle counts derived
`define CLK_NS        100
`define T_PW_NS       450
`define T_CYC_NS      1000
`define T_EXEC_NS     2000
`define PW_CYC        ((`T_PW_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_CYC       ((`T_CYC_NS + `CLK_NS - 1) / `CLK_NS)
`define EXEC_CYC      ((`T_EXEC_NS + `CLK_NS - 1) / `CLK_NS)
// strap decode {high, low}
`define IF_PARALLEL   2'h0
`define IF_I2C        2'h1
`define IF_SPI        2'h2
// display memory
`define BLANK_CHAR    8'h20
`define MEM_LAST      7'h7F
// instruction and status bit positions
`define INS_SETADDR   7
`define INS_CGRAM     6
`define INS_FUNC      5
`define INS_SHIFT     4
`define INS_DISP      3
`define INS_ENTRY     2
`define INS_HOME      1
`define INS_CLEAR     0
`define BUSY_BIT      7
// reset defaults
`define RST_WIDE      1'b1
`define RST_TWOLINE   1'b0
`define RST_FONT      1'b0
`define RST_DISP      1'b0
`define RST_INC       1'b1
`define RST_SHIFT     1'b0
// host register offsets
`define REG_CMD       8'h00
`define REG_DATA      8'h04
`define REG_READ      8'h08
`define REG_RDATA     8'h0C
`define REG_STATUS    8'h10
`define REG_MODE      8'h14
`endif

// *** rtl/lcd_port_pkg.sv ***
// state types for both ends of the display port
package lcd_port_pkg;
	typedef enum logic [1:0] {ST_INIT_FILL, ST_CLEAR_FILL, ST_EXEC, ST_IDLE} coreState_e;
	typedef enum logic [1:0] {H_IDLE, H_POLL, H_XFER} hostState_e;
endpackage

// *** rtl/lcd_bus_if.sv ***
// strobed parallel bus between host and display controller
`timescale 1ns/1ps
interface lcd_bus_if;
	logic       enable;
	logic       registerSelectLine;
	logic       readWrite;
	logic [7:0] hostData;
	logic       hostOe;
	logic [7:0] devData;
	logic       devOe;
	logic [7:0] dataLines;
	// resolved data lines, idle lines float high
	assign dataLines = devOe ? devData : (hostOe ? hostData : 8'hFF);
	modport device (input enable, input registerSelectLine, input readWrite,
		input dataLines, output devData, output devOe);
	modport host (output enable, output registerSelectLine, output readWrite,
		output hostData, output hostOe, input dataLines);
endinterface

// *** rtl/lcd_host_end.sv ***
// host end: command registers, two-entry buffer, busy polling, strobe timing
`timescale 1ns/1ps
`include "lcd_port_consts.svh"
module lcd_host_end
	import lcd_port_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	lcd_bus_if.host         bus,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrStrobe,
	input  wire logic       rdStrobe,
	output logic [7:0]      rdData,
	output logic            cmdReady,
	output logic            hostBusy
);
	hostState_e state, next_state;
	logic [9:0] fifoMem [0:1];
	logic [9:0] next_fifo0, next_fifo1, pushWord, cur, next_cur;
	logic       wrPtr, next_wrPtr, rdPtr, next_rdPtr, push, pop;
	logic [1:0] count, next_count;
	logic [3:0] cnt, next_cnt;
	logic       second, next_second, narrow, next_narrow, finish;
	logic [7:0] rxByte, next_rxByte, rdResult, next_rdResult, next_rdData;
	logic       next_enable, next_regSel, next_rw, next_hostOe;
	logic [7:0] next_hostData;

	// register port, buffer and bus sequencer
	always_comb begin
		next_state = state;
		next_fifo0 = fifoMem[0];
		next_fifo1 = fifoMem[1];
		next_wrPtr = wrPtr;
		next_rdPtr = rdPtr;
		next_cur = cur;
		next_cnt = cnt;
		next_second = second;
		next_narrow = narrow;
		next_rxByte = rxByte;
		next_rdResult = rdResult;
		push = 1'b0;
		pop = 1'b0;
		finish = 1'b0;
		pushWord = 10'h000;
		// writes from software; a full buffer refuses command, data and read writes, cmdReady warns
		if (wrStrobe) begin
			case (addr)
				`REG_CMD: pushWord = {2'h0, wrData};
				`REG_DATA: pushWord = {2'h1, wrData};
				`REG_READ: pushWord = {1'b1, wrData[0], 8'h00};
				`REG_MODE: next_narrow = wrData[0];
				default: pushWord = 10'h000;
			endcase
			push = (addr == `REG_CMD || addr == `REG_DATA || addr == `REG_READ)
				&& count != 2'h2;
		end
		if (push) begin
			if (wrPtr) begin
				next_fifo1 = pushWord;
			end else begin
				next_fifo0 = pushWord;
			end
			next_wrPtr = !wrPtr;
		end
		// sequencer: each byte is preceded by busy polls until clear
		case (state)
			H_IDLE: begin
				if (count != 2'h0) begin
					pop = 1'b1;
					next_cur = fifoMem[rdPtr];
					next_rdPtr = !rdPtr;
					next_state = H_POLL;
					next_cnt = 4'h0;
					next_second = 1'b0;
				end
			end
			H_POLL, H_XFER: begin
				next_cnt = cnt + 4'h1;
				// last cycle with the strobe high: device data have settled
				if (cnt == 4'(`PW_CYC)) begin
					if (!narrow) begin
						next_rxByte = bus.dataLines;
					end else if (!second) begin
						next_rxByte[7:4] = bus.dataLines[7:4];
					end else begin
						next_rxByte[3:0] = bus.dataLines[7:4];
					end
				end
				if (cnt == 4'(`CYC_CYC - 1)) begin
					next_cnt = 4'h0;
					if (narrow && !second) begin
						next_second = 1'b1;
					end else begin
						next_second = 1'b0;
						finish = 1'b1;
					end
				end
				if (finish && state == H_POLL && !rxByte[`BUSY_BIT]) begin
					next_state = H_XFER;
				end
				if (finish && state == H_XFER) begin
					next_state = H_IDLE;
					if (cur[9]) begin
						next_rdResult = rxByte;
					end
				end
			end
			default: begin
				next_state = H_IDLE;
			end
		endcase
		next_count = count + {1'b0, push} - {1'b0, pop};
		// pin levels follow the next step and stand still through a strobe
		next_enable = (next_state != H_IDLE) && (next_cnt >= 4'h1)
			&& (next_cnt <= 4'(`PW_CYC));
		next_regSel = (next_state == H_XFER) ? cur[8] : 1'b0;
		next_rw = (next_state != H_XFER) || next_cur[9];
		next_hostOe = (next_state != H_IDLE) && !next_rw;
		next_hostData = !narrow ? next_cur[7:0]
			: (next_second ? {next_cur[3:0], 4'h0} : {next_cur[7:4], 4'h0});
		next_rdData = 8'h00;
		if (rdStrobe) begin
			case (addr)
				`REG_RDATA: next_rdData = rdResult;
				`REG_STATUS: next_rdData = {5'h00, count == 2'h2, count != 2'h0,
					state != H_IDLE};
				`REG_MODE: next_rdData = {7'h00, narrow};
				default: next_rdData = 8'h00;
			endcase
		end
	end

	// registered state and pins
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state <= H_IDLE;
			fifoMem[0] <= 10'h000;
			fifoMem[1] <= 10'h000;
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
			count <= 2'h0;
			cur <= 10'h000;
			cnt <= 4'h0;
			second <= 1'b0;
			narrow <= 1'b0;
			rxByte <= 8'h00;
			rdResult <= 8'h00;
			rdData <= 8'h00;
			cmdReady <= 1'b1;
			hostBusy <= 1'b0;
			bus.enable <= 1'b0;
			bus.registerSelectLine <= 1'b0;
			bus.readWrite <= 1'b1;
			bus.hostData <= 8'h00;
			bus.hostOe <= 1'b0;
		end else begin
			state <= next_state;
			fifoMem[0] <= next_fifo0;
			fifoMem[1] <= next_fifo1;
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
			cur <= next_cur;
			cnt <= next_cnt;
			second <= next_second;
			narrow <= next_narrow;
			rxByte <= next_rxByte;
			rdResult <= next_rdResult;
			rdData <= next_rdData;
			cmdReady <= next_count != 2'h2;
			hostBusy <= (next_state != H_IDLE) || (next_count != 2'h0);
			bus.enable <= next_enable;
			bus.registerSelectLine <= next_regSel;
			bus.readWrite <= next_rw;
			bus.hostData <= next_hostData;
			bus.hostOe <= next_hostOe;
		end
	end
endmodule

// *** tb/lcd_port_assertions.sv ***
// protocol assertions on the wires between host end and device end
`timescale 1ns/1ps
module lcd_port_assertions (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       enable,
	input  wire logic       registerSelectLine,
	input  wire logic       readWrite,
	input  wire logic [7:0] hostData,
	input  wire logic       hostOe,
	input  wire logic [7:0] devData,
	input  wire logic       devOe,
	input  wire logic       busyIndication,
	input  wire logic       wideBus
);
	logic       enPrev;
	logic       wbPrev;
	logic       nibOdd;
	logic       next_nibOdd;
	logic [7:0] initCnt;
	logic [7:0] next_initCnt;
	logic       wrEnd;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// first cycle a write strobe is seen low again
	assign wrEnd = enPrev && !enable && !readWrite;
	// nibble phase and cycles since reset; count saturates so it never wraps
	always_comb begin
		next_nibOdd = nibOdd;
		next_initCnt = (initCnt == 8'hFF) ? initCnt : initCnt + 8'h01;
		if (wbPrev != wideBus) begin
			next_nibOdd = 1'b0;
		end else if (enPrev && !enable && !wideBus) begin
			next_nibOdd = !nibOdd;
		end
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			enPrev <= 1'b0;
			wbPrev <= 1'b1;
			nibOdd <= 1'b0;
			initCnt <= 8'h00;
		end else begin
			enPrev <= enable;
			wbPrev <= wideBus;
			nibOdd <= next_nibOdd;
			initCnt <= next_initCnt;
		end
	end
	sequence s_pulse;
		enable [*5] ##1 !enable;
	endsequence
	sequence s_quiet;
		!busyIndication [*4];
	endsequence
	property p_pulse;
		$rose(enable) |-> s_pulse;
	endproperty
	property p_clash;
		!(hostOe && devOe);
	endproperty
	property p_devRead;
		devOe |-> readWrite;
	endproperty
	property p_answer;
		$rose(enable) && readWrite |-> ##[1:2] devOe;
	endproperty
	property p_setup;
		enable |-> $stable(registerSelectLine) && $stable(readWrite);
	endproperty
	property p_wdata;
		enable && !readWrite |-> hostOe && $stable(hostData);
	endproperty
	property p_hostLow;
		hostOe && enable && !wideBus |-> hostData[3:0] == 4'h0;
	endproperty
	property p_devLow;
		devOe && !wideBus |-> devData[3:0] == 4'h0;
	endproperty
	property p_busyWide;
		wrEnd && wideBus |-> ##[0:4] busyIndication;
	endproperty
	property p_firstNib;
		wrEnd && !wideBus && !nibOdd |-> s_quiet;
	endproperty
	property p_secondNib;
		wrEnd && !wideBus && nibOdd |-> ##[0:4] busyIndication;
	endproperty
	property p_init;
		initCnt < 8'd120 |-> busyIndication;
	endproperty
	a_pulse: assert property (p_pulse) else $error("strobe width wrong");
	a_clash: assert property (p_clash) else $error("both ends drive");
	a_devRead: assert property (p_devRead) else $error("device drives on write");
	a_answer: assert property (p_answer) else $error("no read answer");
	a_setup: assert property (p_setup) else $error("select moved in strobe");
	a_wdata: assert property (p_wdata) else $error("write data unsteady");
	a_hostLow: assert property (p_hostLow) else $error("low lines driven");
	a_devLow: assert property (p_devLow) else $error("device low lines set");
	a_busyWide: assert property (p_busyWide) else $error("no busy after byte");
	a_firstNib: assert property (p_firstNib) else $error("busy after first nibble");
	a_secondNib: assert property (p_secondNib) else $error("no busy after pair");
	a_init: assert property (p_init) else $error("busy dropped in init");
endmodule

// *** tb/tb.sv ***
// self-checking bench joining host end and device end over the display port
`timescale 1ns/1ps
`include "lcd_port_consts.svh"
module tb;
	logic        ref_clk;
	logic        rstn;
	logic [7:0]  addr;
	logic [7:0]  wrData;
	logic        wrStrobe;
	logic        rdStrobe;
	logic [7:0]  rdData;
	logic        cmdReady;
	logic        hostBusy;
	logic        strapHigh;
	logic        strapLow;
	logic        busyIndication;
	logic [1:0]  ifMode;
	logic        wideBus;
	logic        twoLine;
	logic        bigFont;
	logic        displayOn;
	logic        cursorOn;
	logic        blinkOn;
	logic        addrIncrement;
	logic        displayShift;
	logic [6:0]  addressCounter;
	logic [31:0] seed;
	logic [7:0]  wq[$];
	logic        enSeen;
	logic [7:0]  d;
	int          errors;
	int          checksDone;
	int          n;
	lcd_bus_if bus ();
	lcd_device_end lcd_device_end_i (.ref_clk(ref_clk), .rstn(rstn), .bus(bus),
		.interfaceStrapHigh(strapHigh), .interfaceStrapLow(strapLow),
		.busyIndication(busyIndication), .ifMode(ifMode), .wideBus(wideBus),
		.twoLine(twoLine), .bigFont(bigFont), .displayOn(displayOn), .cursorOn(cursorOn),
		.blinkOn(blinkOn), .addrIncrement(addrIncrement), .displayShift(displayShift),
		.addressCounter(addressCounter));
	lcd_host_end lcd_host_end_i (.ref_clk(ref_clk), .rstn(rstn), .bus(bus), .addr(addr),
		.wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
		.cmdReady(cmdReady), .hostBusy(hostBusy));
	lcd_port_assertions lcd_port_assertions_i (.ref_clk(ref_clk), .rstn(rstn),
		.enable(bus.enable), .registerSelectLine(bus.registerSelectLine),
		.readWrite(bus.readWrite), .hostData(bus.hostData), .hostOe(bus.hostOe),
		.devData(bus.devData), .devOe(bus.devOe), .busyIndication(busyIndication),
		.wideBus(wideBus));
	// clock, 100 ns period
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// record every write transfer as seen on the resolved lines
	always @(posedge ref_clk) begin
		enSeen <= bus.enable;
		if (enSeen && !bus.enable && !bus.readWrite) begin
			wq.push_back(bus.dataLines);
		end
	end
	function automatic logic [7:0] rnd_byte();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task automatic end_sim();
		$display("errors %0d checks %0d", errors, checksDone);
		if (errors == 0 && checksDone > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checksDone++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		addr <= a;
		wrData <= v;
		wrStrobe <= 1'b1;
		@(posedge ref_clk);
		wrStrobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge ref_clk);
		rdStrobe <= 1'b0;
		@(negedge ref_clk);
		v = rdData;
	endtask
	// wait until host queue and device are both quiet, bounded
	task automatic idle();
		int k;
		k = 0;
		@(negedge ref_clk);
		while (hostBusy !== 1'b0 || busyIndication !== 1'b0) begin
			@(negedge ref_clk);
			k++;
			if (k > 3000) begin
				errors++;
				$display("CHECK FAILED at %0t: wait ran out", $time);
				end_sim();
			end
		end
	endtask
	task automatic op(input logic [7:0] a, input logic [7:0] v);
		wr(a, v);
		idle();
	endtask
	task automatic rdq(input logic sel, output logic [7:0] v);
		op(`REG_READ, {7'h00, sel});
		rd(`REG_RDATA, v);
	endtask
	// straps are taken at reset release, so each setting needs a reset
	task automatic do_reset(input logic sh, input logic sl);
		@(posedge ref_clk);
		rstn <= 1'b0;
		strapHigh <= sh;
		strapLow <= sl;
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
	endtask
	task automatic run_data(input logic narrow);
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] got;
		for (int i = 0; i < 6; i++) begin
			a = rnd_byte() & 8'h3F;
			b = (i == 0) ? 8'hF0 : (i == 1) ? 8'h0F : rnd_byte();
			op(`REG_CMD, 8'h80 | a);
			wq.delete();
			op(`REG_DATA, b);
			if (narrow) begin
				cmp(8'(wq.size()), 8'h02);
				cmp(wq[0], {b[7:4], 4'h0});
				cmp(wq[1], {b[3:0], 4'h0});
			end else begin
				cmp(8'(wq.size()), 8'h01);
				cmp(wq[0], b);
			end
			rdq(1'b0, got);
			cmp(got, a + 8'h01);
			op(`REG_CMD, 8'h80 | a);
			rdq(1'b1, got);
			cmp(got, b);
		end
	endtask
	// hang guard for the whole run
	initial begin
		repeat (100000) @(posedge ref_clk);
		errors++;
		$display("CHECK FAILED at %0t: run too long", $time);
		end_sim();
	end
	initial begin
		rstn = 1'b0;
		addr = 8'h00;
		wrData = 8'h00;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		strapHigh = 1'b0;
		strapLow = 1'b0;
		errors = 0;
		checksDone = 0;
		seed = 32'h4642_f3c6;
		// spi, i2c, then parallel; busy must fall with no host traffic
		for (int m = 2; m >= 0; m--) begin
			do_reset(m[1], m[0]);
			idle();
			cmp({6'h00, ifMode}, {6'h00, (m == 2) ? `IF_SPI : (m == 1) ? `IF_I2C : `IF_PARALLEL});
		end
		cmp({wideBus, twoLine, bigFont, addrIncrement, displayShift}, 8'h12);
		cmp({displayOn, cursorOn, blinkOn}, 8'h00);
		cmp({1'b0, addressCounter}, 8'h00);
		rd(`REG_STATUS, d);
		cmp(d, 8'h00);
		wr(8'h3C, 8'hA5);
		rd(8'h3C, d);
		cmp(d, 8'h00);
		// whole memory reads blank; read also steps the address
		op(`REG_CMD, 8'h80);
		for (int j = 0; j < 128; j++) begin
			rdq(1'b1, d);
			cmp(d, 8'h20);
		end
		run_data(1'b0);
		op(`REG_CMD, 8'h20);
		wr(`REG_MODE, 8'h01);
		cmp({7'h00, wideBus}, 8'h00);
		run_data(1'b1);
		op(`REG_CMD, 8'h30);
		wr(`REG_MODE, 8'h00);
		cmp({7'h00, wideBus}, 8'h01);
		// fill the buffer until refused while the host is still polling before the first byte
		op(`REG_CMD, 8'h01);
		n = 0;
		while (cmdReady === 1'b1 && n < 6) begin
			wr(`REG_DATA, 8'h41 + 8'(n));
			n++;
			@(negedge ref_clk);
		end
		cmp({7'h00, n >= 2}, 8'h01);
		wr(`REG_DATA, 8'h7E);
		idle();
		rdq(1'b0, d);
		cmp(d, 8'(n));
		op(`REG_CMD, 8'h80);
		for (int j = 0; j <= n; j++) begin
			rdq(1'b1, d);
			cmp(d, (j < n) ? 8'h41 + 8'(j) : 8'h20);
		end
		// software setup by instructions, for when the power-up self start is not trusted
		op(`REG_CMD, 8'h3C);
		cmp({5'h00, wideBus, twoLine, bigFont}, 8'h07);
		op(`REG_CMD, 8'h0F);
		cmp({5'h00, displayOn, cursorOn, blinkOn}, 8'h07);
		op(`REG_CMD, 8'h05);
		cmp({6'h00, addrIncrement, displayShift}, 8'h01);
		// write at 5 steps down to 4, cursor right back to 5, glyph address only costs time
		op(`REG_CMD, 8'h85);
		op(`REG_DATA, 8'h55);
		op(`REG_CMD, 8'h14);
		op(`REG_CMD, 8'h40);
		rdq(1'b0, d);
		cmp(d, 8'h05);
		op(`REG_CMD, 8'h02);
		rdq(1'b0, d);
		cmp(d, 8'h00);
		end_sim();
	end
endmodule
